// ===== common/cpsr_consts.svh
// Offsets, field positions, reset values and timing counts of the protection status bank
`ifndef CPSR_CONSTS_SVH
`define CPSR_CONSTS_SVH
`define CPSR_OFS_CAPS        8'hA0
`define CPSR_OFS_TOPO_LO     8'hA1
`define CPSR_OFS_TOPO_HI     8'hA2
`define CPSR_OFS_KSV_PORT    8'hA3
`define CPSR_OFS_DEBUG       8'hC0
`define CPSR_CAPS_RESET      8'h13
`define CPSR_DEBUG_RESET     8'h00
`define CPSR_CAPS_MASK       8'h73
`define CPSR_DEBUG_MASK      8'h0F
`define CPSR_CAPS_REPEATER   6
`define CPSR_CAPS_LIST_RDY   5
`define CPSR_CAPS_FAST_BUS   4
`define CPSR_CAPS_FEATURES   1
`define CPSR_CAPS_REAUTH     0
`define CPSR_TOPO_MAXDEV     7
`define CPSR_TOPO_MAXCAS     3
`define CPSR_DBG_CHKSUM      3
`define CPSR_DBG_FAST_LINK_VERIFY     2
`define CPSR_DBG_TMR_SPEED   1
`define CPSR_DBG_MST_FAST    0
`define CPSR_FINE_FAST       8'h02
`define CPSR_COARSE_FAST     8'h10
`define CPSR_FINE_SLOW       8'h10
`define CPSR_COARSE_SLOW     8'h80
`define CPSR_LIST_DEPTH      128
`define CPSR_LIST_AW         7
`endif

// ===== common/cpsr_pkg.sv
// Types of the protection status bank
package cpsr_pkg;
   typedef logic [7:0] cpsr_byte_t;
   typedef logic [6:0] cpsr_lidx_t;
endpackage

// ===== dv/cpsr_rx_model.sv
// Downstream receiver model: status source and key list writer
`timescale 1ns/1ps
module cpsr_rx_model
   import cpsr_pkg::*;
(
   input  wire logic            clk_in,
   output logic                 valid_out,
   output logic                 key_rdy_out,
   output cpsr_pkg::cpsr_byte_t caps_out,
   output cpsr_pkg::cpsr_byte_t lo_out,
   output cpsr_pkg::cpsr_byte_t hi_out,
   output logic                 wr_out,
   output logic                 clr_out,
   output cpsr_pkg::cpsr_byte_t data_out
);
   initial begin
      {valid_out, key_rdy_out, wr_out, clr_out} = 4'h0;
      {caps_out, lo_out, hi_out, data_out} = 32'h0;
   end
   // Values are only meaningful with the load pulse
   task automatic publish(input cpsr_byte_t c, l, h, input logic k);
      {caps_out, lo_out, hi_out} = {c, l, h};
      key_rdy_out = k;
      valid_out = 1'b1;
      @(negedge clk_in);
      valid_out = 1'b0;
      {caps_out, lo_out, hi_out} = ~{c, l, h};
   endtask
   task automatic push(input cpsr_byte_t b);
      data_out = b;
      wr_out = 1'b1;
      @(negedge clk_in);
      wr_out = 1'b0;
      data_out = ~b;
      @(negedge clk_in);
   endtask
   task automatic clear;
      clr_out = 1'b1;
      @(negedge clk_in);
      clr_out = 1'b0;
   endtask
endmodule

// ===== dv/test_cpsr_regs.sv
// Self-checking bench for the protection status register bank
`timescale 1ns/1ps
`include "cpsr_consts.svh"
module test_cpsr_regs;
   import cpsr_pkg::*;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       frame = 1'b0;
   logic       k;
   cpsr_byte_t addr = 8'h00;
   cpsr_byte_t wdata = 8'h00;
   cpsr_byte_t rdata, caps, lo, hi, ldat, s, c, l, h;
   logic       cv, key, lwr, lclr, f_ck, f_ts, f_mf, f_is, rep, fine, coarse;
   int         n_mismatch = 0;
   int         n_tests = 0;
   int         n_fine = 0;
   int         n_coarse = 0;
   cpsr_byte_t q[$];
   cpsr_byte_t ra[6] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hC0, 8'h55};
   cpsr_byte_t re[6] = '{8'h13, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (fine === 1'b1) n_fine++;
      if (coarse === 1'b1) n_coarse++;
   end
   cpsr_rx_model rx_u (.clk_in(clk), .valid_out(cv), .key_rdy_out(key), .caps_out(caps), .lo_out(lo),
      .hi_out(hi), .wr_out(lwr), .clr_out(lclr), .data_out(ldat));
   cpsr_regs dut_u (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .RX_CAPS_VALID_IN(cv), .RX_CAPS_IN(caps),
      .RX_TOPO_LO_IN(lo), .RX_TOPO_HI_IN(hi), .KEY_READY_IN(key), .LIST_WR_IN(lwr),
      .LIST_WDATA_IN(ldat), .LIST_CLEAR_IN(lclr), .FRAME_IN(frame), .LINE_CHECKSUM_EN_OUT(f_ck),
      .AUTH_TIMER_SPEEDUP_OUT(f_ts), .MASTER_FAST_TIMING_OUT(f_mf), .INDIRECT_STATUS_REGISTER_FAST_OUT(f_is),
      .REPEATER_VALID_OUT(rep), .FINE_CHECK_OUT(fine), .COARSE_CHECK_OUT(coarse));
   function automatic cpsr_byte_t dbg_pins(input cpsr_byte_t d);
      return {4'h0, d[3], d[1], d[0], d[0]};
   endfunction
   task automatic chk(input string n, input cpsr_byte_t e, input cpsr_byte_t g);
      n_tests++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", n, e, g);
         n_mismatch++;
      end
   endtask
   task automatic wr_reg(input cpsr_byte_t a, input cpsr_byte_t d);
      {rd, addr, wdata, wr} = {1'b0, a, d, 1'b1};
      @(negedge clk);
      wr = 1'b0;
   endtask
   // Leaves the strobe up so reads run back to back
   task automatic rd_reg(input cpsr_byte_t a, output cpsr_byte_t d);
      {addr, rd} = {a, 1'b1};
      @(negedge clk);
      d = rdata;
   endtask
   task automatic do_reset;
      {rd, rstn} = 2'b00;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      {n_fine, n_coarse} = 64'h0;
   endtask
   task automatic frames(input int n);
      repeat (n) begin
         frame = 1'b1;
         @(negedge clk);
         frame = 1'b0;
         repeat (3) @(negedge clk);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #400000;
      n_mismatch++;
      final_report();
   end
   initial begin
      void'($urandom(32'hA3E7));
      do_reset();
      foreach (ra[i]) begin
         rd_reg(ra[i], s);
         chk("reset", re[i], s);
      end
      for (int i = 0; i < 8; i++) begin
         {c, l, h, k} = (i == 0) ? 25'h1FFFFFF : 25'($urandom);
         rx_u.publish(c, l, h, k);
         rd_reg(`CPSR_OFS_CAPS, s);
         chk("caps", c & `CPSR_CAPS_MASK, s);
         chk("rep", {7'h0, c[6] & k}, {7'h0, rep});
         rd_reg(`CPSR_OFS_TOPO_LO, s);
         chk("topo_lo", l, s);
         rd_reg(`CPSR_OFS_TOPO_HI, s);
         chk("topo_hi", h & 8'h0F, s);
      end
      wr_reg(`CPSR_OFS_CAPS, 8'hFF);
      rd_reg(`CPSR_OFS_CAPS, s);
      chk("caps_wr", c & `CPSR_CAPS_MASK, s);
      for (int i = 0; i < 16; i++) begin
         h = {4'($urandom), 4'(i)};
         wr_reg(`CPSR_OFS_DEBUG, h);
         rd_reg(`CPSR_OFS_DEBUG, s);
         chk("debug", h & `CPSR_DEBUG_MASK, s);
         chk("pins", dbg_pins(h), {4'h0, f_ck, f_ts, f_mf, f_is});
      end
      rd = 1'b0;
      rx_u.clear();
      repeat (6) begin
         q.push_back(8'($urandom));
         rx_u.push(q[$]);
      end
      foreach (q[i]) begin
         rd_reg(`CPSR_OFS_KSV_PORT, s);
         chk("list", q[i], s);
      end
      rd_reg(`CPSR_OFS_KSV_PORT, s);
      chk("list_empty", 8'h00, s);
      do_reset();
      wr_reg(`CPSR_OFS_DEBUG, 8'h04);
      frames(32);
      chk("fine_fast", 8'd16, 8'(n_fine));
      chk("coarse_fast", 8'd2, 8'(n_coarse));
      do_reset();
      frames(128);
      chk("fine_slow", 8'd8, 8'(n_fine));
      chk("coarse_slow", 8'd1, 8'(n_coarse));
      final_report();
   end
endmodule

// ===== src/cpsr_frame_div.sv
// Frame divider giving fine and coarse link check pulses
`timescale 1ns/1ps
`include "cpsr_consts.svh"
module cpsr_frame_div
   import cpsr_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic frame_in,
   input  wire logic fast_in,
   output logic      fine_out,
   output logic      coarse_out
);
   logic [7:0] cnt_ff;
   wire  [7:0] nxt_cnt  = cnt_ff + 8'h01;
   wire  [7:0] fine_p   = fast_in ? `CPSR_FINE_FAST : `CPSR_FINE_SLOW;
   wire  [7:0] coarse_p = fast_in ? `CPSR_COARSE_FAST : `CPSR_COARSE_SLOW;
   wire        wrap     = frame_in && (nxt_cnt >= coarse_p);
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_ff     <= 8'h00;
         fine_out   <= 1'b0;
         coarse_out <= 1'b0;
      end else begin
         fine_out   <= frame_in && ((nxt_cnt & (fine_p - 8'h01)) == 8'h00);
         coarse_out <= wrap;
         if (frame_in) begin
            cnt_ff <= wrap ? 8'h00 : nxt_cnt;
         end
      end
   end
endmodule

// ===== src/cpsr_list_mem.sv
// Key-vector list storage with registered read data
`timescale 1ns/1ps
`include "cpsr_consts.svh"
module cpsr_list_mem
   import cpsr_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              we_in,
   input  wire cpsr_pkg::cpsr_lidx_t waddr_in,
   input  wire cpsr_pkg::cpsr_byte_t wdata_in,
   input  wire cpsr_pkg::cpsr_lidx_t raddr_in,
   output      cpsr_pkg::cpsr_byte_t rdata_out
);
   cpsr_byte_t mem [0:`CPSR_LIST_DEPTH-1];
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      rdata_out <= mem[raddr_in];
   end
endmodule

// ===== src/cpsr_regs.sv
// Content protection receiver status and debug register bank
// Summary of operation
// RULE1 - Bit6 repeater, valid after key ready
// RULE2 - Bit5 list ready and value computed
// RULE3 - Bit4 fast bus support, may be ignored
// RULE4 - Bit1 enhanced features supported
// RULE5 - Bit0 video accepted during reauthentication
// RULE6 - Topology low bit7 too many devices
// RULE7 - Bits6:0 downstream device count
// RULE8 - Topology high bit3 cascade over seven
// RULE9 - Bits2:0 cascade depth below repeater
// RULE10 - Each list port read returns next byte
// RULE11 - Debug bit3 enables per-line colour checksums
// RULE12 - Fast verify: fine 2, coarse 16 frames
// RULE13 - Slow verify: fine 16, coarse 128 frames
// RULE14 - Debug bit1 speeds authentication timers
// RULE15 - Debug bit0 selects master fast timing
// RULE16 - Fast timing mirrored in indirect status
// RULE17 - Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "cpsr_consts.svh"
module cpsr_regs
   import cpsr_pkg::*;
(
   input  wire logic                 CORE_CLK_IN,
   input  wire logic                 RSTN_IN,
   input  wire cpsr_pkg::cpsr_byte_t REG_ADDR_IN,
   input  wire cpsr_pkg::cpsr_byte_t REG_WDATA_IN,
   input  wire logic                 REG_WR_IN,
   input  wire logic                 REG_RD_IN,
   output      cpsr_pkg::cpsr_byte_t REG_RDATA_OUT,
   input  wire logic                 RX_CAPS_VALID_IN,
   input  wire cpsr_pkg::cpsr_byte_t RX_CAPS_IN,
   input  wire cpsr_pkg::cpsr_byte_t RX_TOPO_LO_IN,
   input  wire cpsr_pkg::cpsr_byte_t RX_TOPO_HI_IN,
   input  wire logic                 KEY_READY_IN,
   input  wire logic                 LIST_WR_IN,
   input  wire cpsr_pkg::cpsr_byte_t LIST_WDATA_IN,
   input  wire logic                 LIST_CLEAR_IN,
   input  wire logic                 FRAME_IN,
   output logic                      LINE_CHECKSUM_EN_OUT,
   output logic                      AUTH_TIMER_SPEEDUP_OUT,
   output logic                      MASTER_FAST_TIMING_OUT,
   output logic                      INDIRECT_STATUS_REGISTER_FAST_OUT,
   output logic                      REPEATER_VALID_OUT,
   output logic                      FINE_CHECK_OUT,
   output logic                      COARSE_CHECK_OUT
);
   import cpsr_pkg::*;

   cpsr_byte_t caps_ff, topo_lo_ff, topo_hi_ff, debug_ff, rdata_ff;
   cpsr_lidx_t wptr_ff, rptr_ff;
   logic       rd_list_ff;
   cpsr_byte_t list_rdata;

   function automatic logic addr_hit(input cpsr_byte_t addr, input cpsr_byte_t ofs);
      return addr == ofs;
   endfunction

   wire sel_caps  = addr_hit(REG_ADDR_IN, `CPSR_OFS_CAPS);
   wire sel_lo    = addr_hit(REG_ADDR_IN, `CPSR_OFS_TOPO_LO);
   wire sel_hi    = addr_hit(REG_ADDR_IN, `CPSR_OFS_TOPO_HI);
   wire sel_list  = addr_hit(REG_ADDR_IN, `CPSR_OFS_KSV_PORT);
   wire sel_dbg   = addr_hit(REG_ADDR_IN, `CPSR_OFS_DEBUG);
   // Empty list reads zero and leaves the pointer; a full list of 128 reads as empty
   wire list_empty = rptr_ff == wptr_ff;
   wire list_pop  = REG_RD_IN && sel_list && !list_empty; // [RULE10]
   wire dbg_wr    = REG_WR_IN && sel_dbg;
   wire cpsr_byte_t nxt_debug = REG_WDATA_IN & `CPSR_DEBUG_MASK; // [RULE17]
   wire cpsr_byte_t nxt_rdata =
      sel_caps ? caps_ff :
      sel_lo   ? topo_lo_ff :
      sel_hi   ? (topo_hi_ff & 8'h0F) : // [RULE8] [RULE9] [RULE17]
      sel_dbg  ? debug_ff : 8'h00;

   cpsr_list_mem u_mem (
      .clk_in    (CORE_CLK_IN),
      .we_in     (LIST_WR_IN),
      .waddr_in  (wptr_ff),
      .wdata_in  (LIST_WDATA_IN),
      .raddr_in  (rptr_ff),
      .rdata_out (list_rdata)
   );

   cpsr_frame_div u_div (
      .clk_in     (CORE_CLK_IN),
      .rst_n_in   (RSTN_IN),
      .frame_in   (FRAME_IN),
      .fast_in    (debug_ff[`CPSR_DBG_FAST_LINK_VERIFY]), // [RULE12] [RULE13]
      .fine_out   (FINE_CHECK_OUT),
      .coarse_out (COARSE_CHECK_OUT)
   );

   // Status mirrors from the downstream receiver
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RSTN_IN) begin
         caps_ff    <= `CPSR_CAPS_RESET;
         topo_lo_ff <= 8'h00;
         topo_hi_ff <= 8'h00;
      end else if (RX_CAPS_VALID_IN) begin
         caps_ff    <= RX_CAPS_IN & `CPSR_CAPS_MASK; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE17]
         topo_lo_ff <= RX_TOPO_LO_IN; // [RULE6] [RULE7]
         topo_hi_ff <= RX_TOPO_HI_IN & 8'h0F;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RSTN_IN) begin
         debug_ff <= `CPSR_DEBUG_RESET;
      end else if (dbg_wr) begin
         debug_ff <= nxt_debug;
      end
   end

   // List pointers; read pointer advances per port read of a non-empty list
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RSTN_IN || LIST_CLEAR_IN) begin
         wptr_ff <= 7'h00;
         rptr_ff <= 7'h00;
      end else begin
         if (LIST_WR_IN) begin
            wptr_ff <= wptr_ff + 7'h01;
         end
         if (list_pop) begin
            rptr_ff <= rptr_ff + 7'h01; // [RULE10]
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RSTN_IN) begin
         rdata_ff   <= 8'h00;
         rd_list_ff <= 1'b0;
      end else begin
         rdata_ff   <= nxt_rdata;
         rd_list_ff <= list_pop;
      end
   end

   assign REG_RDATA_OUT          = rd_list_ff ? list_rdata : rdata_ff;
   assign LINE_CHECKSUM_EN_OUT   = debug_ff[`CPSR_DBG_CHKSUM]; // [RULE11]
   assign AUTH_TIMER_SPEEDUP_OUT = debug_ff[`CPSR_DBG_TMR_SPEED]; // [RULE14]
   assign MASTER_FAST_TIMING_OUT = debug_ff[`CPSR_DBG_MST_FAST]; // [RULE15]
   assign INDIRECT_STATUS_REGISTER_FAST_OUT       = debug_ff[`CPSR_DBG_MST_FAST]; // [RULE16]
   assign REPEATER_VALID_OUT     = KEY_READY_IN && caps_ff[`CPSR_CAPS_REPEATER]; // [RULE1]

   logic [7:0] frm_cnt;
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RSTN_IN || COARSE_CHECK_OUT) begin
         frm_cnt <= 8'h00;
      end else if (FRAME_IN) begin
         frm_cnt <= frm_cnt + 8'h01;
      end
   end

   sequence dbg_write_s;
      dbg_wr;
   endsequence

   dbg_update_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE15]
      dbg_write_s |=> MASTER_FAST_TIMING_OUT == $past(REG_WDATA_IN[0]))
      else $error("fast timing bit not updated");
   mirror_same_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE16]
      INDIRECT_STATUS_REGISTER_FAST_OUT == MASTER_FAST_TIMING_OUT)
      else $error("indirect mirror differs");
   dbg_reserved_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE17]
      debug_ff[7:4] == 4'h0)
      else $error("reserved debug bits set");
   caps_reserved_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE17]
      caps_ff[7] == 1'b0 && caps_ff[3:2] == 2'b00)
      else $error("reserved capability bits set");
   list_step_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE10]
      list_pop && !LIST_CLEAR_IN |=> rptr_ff == $past(rptr_ff) + 7'h01)
      else $error("list pointer did not step");
   repeater_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE1]
      !KEY_READY_IN |-> !REPEATER_VALID_OUT)
      else $error("repeater flagged before key ready");
   checksum_en_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE11]
      dbg_write_s |=> LINE_CHECKSUM_EN_OUT == $past(REG_WDATA_IN[3]))
      else $error("checksum enable wrong");
   speedup_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE14]
      dbg_write_s |=> AUTH_TIMER_SPEEDUP_OUT == $past(REG_WDATA_IN[1]))
      else $error("timer speedup wrong");
   coarse_fast_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE12]
      COARSE_CHECK_OUT && debug_ff[2] && $stable(debug_ff) |-> frm_cnt <= 8'h10)
      else $error("fast coarse period exceeded");
   coarse_slow_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE13]
      !debug_ff[2] |-> frm_cnt <= 8'h80)
      else $error("slow coarse period exceeded");

   // Frames since the last fine pulse; restarts when the rate is changed
   logic [7:0] fine_cnt_ff;
   wire        lv_change = dbg_wr && (nxt_debug[`CPSR_DBG_FAST_LINK_VERIFY] != debug_ff[`CPSR_DBG_FAST_LINK_VERIFY]);
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RSTN_IN || FINE_CHECK_OUT || lv_change) begin
         fine_cnt_ff <= 8'h00;
      end else if (FRAME_IN) begin
         fine_cnt_ff <= fine_cnt_ff + 8'h01;
      end
   end

   wire unmapped = !(sel_caps || sel_lo || sel_hi || sel_list || sel_dbg);

   sequence status_load_s;
      RX_CAPS_VALID_IN;
   endsequence

   sequence list_read_s;
      list_pop && !LIST_CLEAR_IN;
   endsequence

   sequence empty_read_s;
      REG_RD_IN && sel_list && list_empty && !LIST_CLEAR_IN;
   endsequence

   sequence unmapped_read_s;
      REG_RD_IN && unmapped;
   endsequence

   sequence fine_tick_s;
      FINE_CHECK_OUT;
   endsequence

   sequence coarse_tick_s;
      COARSE_CHECK_OUT;
   endsequence

   // Status mirror follows each load pulse
   repeater_bit_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE1]
      status_load_s |=> caps_ff[`CPSR_CAPS_REPEATER] == $past(RX_CAPS_IN[`CPSR_CAPS_REPEATER]))
      else $error("repeater bit not loaded");

   repeater_on_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE1]
      KEY_READY_IN && caps_ff[`CPSR_CAPS_REPEATER] |-> REPEATER_VALID_OUT)
      else $error("repeater not flagged with key ready");

   list_ready_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE2]
      status_load_s |=> caps_ff[`CPSR_CAPS_LIST_RDY] == $past(RX_CAPS_IN[`CPSR_CAPS_LIST_RDY]))
      else $error("list ready bit not loaded");

   fast_bus_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE3]
      status_load_s |=> caps_ff[`CPSR_CAPS_FAST_BUS] == $past(RX_CAPS_IN[`CPSR_CAPS_FAST_BUS]))
      else $error("fast bus bit not loaded");

   features_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE4]
      status_load_s |=> caps_ff[`CPSR_CAPS_FEATURES] == $past(RX_CAPS_IN[`CPSR_CAPS_FEATURES]))
      else $error("features bit not loaded");

   reauth_video_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE5]
      status_load_s |=> caps_ff[`CPSR_CAPS_REAUTH] == $past(RX_CAPS_IN[`CPSR_CAPS_REAUTH]))
      else $error("reauth video bit not loaded");

   max_devices_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE6]
      status_load_s |=> topo_lo_ff[`CPSR_TOPO_MAXDEV] == $past(RX_TOPO_LO_IN[`CPSR_TOPO_MAXDEV]))
      else $error("device overflow flag not loaded");

   dev_count_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE7]
      status_load_s |=> topo_lo_ff[6:0] == $past(RX_TOPO_LO_IN[6:0]))
      else $error("device count not loaded");

   max_cascade_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE8]
      status_load_s |=> topo_hi_ff[`CPSR_TOPO_MAXCAS] == $past(RX_TOPO_HI_IN[`CPSR_TOPO_MAXCAS]))
      else $error("cascade overflow flag not loaded");

   cascade_depth_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE9]
      status_load_s |=> topo_hi_ff[2:0] == $past(RX_TOPO_HI_IN[2:0]))
      else $error("cascade depth not loaded");

   status_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE7]
      !RX_CAPS_VALID_IN |=> $stable(caps_ff) && $stable(topo_lo_ff) && $stable(topo_hi_ff))
      else $error("status changed without load");

   topo_reserved_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE17]
      topo_hi_ff[7:4] == 4'h0)
      else $error("reserved topology bits set");

   // Key list port
   empty_read_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE10]
      empty_read_s |=> REG_RDATA_OUT == 8'h00 && rptr_ff == $past(rptr_ff))
      else $error("empty list read misbehaved");

   list_data_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE10]
      list_read_s |=> rd_list_ff && REG_RDATA_OUT == list_rdata)
      else $error("list byte not returned");

   ptr_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE10]
      !list_pop && !LIST_CLEAR_IN |=> $stable(rptr_ff))
      else $error("list pointer moved without read");

   unmapped_zero_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE17]
      unmapped_read_s |=> REG_RDATA_OUT == 8'h00)
      else $error("unmapped read not zero");

   // Debug register
   dbg_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE17]
      !dbg_wr |=> $stable(debug_ff))
      else $error("debug changed without write");

   lv_select_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE12]
      dbg_write_s |=> debug_ff[`CPSR_DBG_FAST_LINK_VERIFY] == $past(REG_WDATA_IN[2]))
      else $error("fast verify bit not updated");

   mirror_write_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE16]
      dbg_write_s |=> INDIRECT_STATUS_REGISTER_FAST_OUT == $past(REG_WDATA_IN[0]))
      else $error("indirect mirror not updated");

   // Link check pulses
   fine_slow_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE13]
      !debug_ff[`CPSR_DBG_FAST_LINK_VERIFY] |-> fine_cnt_ff <= 8'h10)
      else $error("slow fine period exceeded");

   fine_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE12]
      fine_tick_s |=> !FINE_CHECK_OUT)
      else $error("fine pulse too long");

   coarse_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN) // [RULE13]
      coarse_tick_s |=> !COARSE_CHECK_OUT)
      else $error("coarse pulse too long");
endmodule
